/* File: rtl/scm_pkg.sv */
// Purpose: Shared constants and types for the curtain mode configuration block.
// Assumes: A single 200 MHz clock; all pin levels synchronous to it.
// Notes:   Strap levels arrive as logic levels, 1 meaning +24 V.
//
// Notes on behaviour
// RQ1: Restart delay is 100 ms with delay select 0, 500 ms with 1.
// RQ2: Master writes 1 to interference flag, then reads it back.
// RQ3: Readback gives 1 while no interference seen since the master set it.
// RQ4: Interference such as contamination or periphery fault clears the flag.
// RQ5: Only the bus master uses the parameter port; never safety relevant.
// RQ6: External muting lamp follows the single output data bit from master.
// RQ7: Four input data bits carry the protocol code sequence, not status.
// RQ8: Straps are sampled once at start-up; changes need a power cycle.
// RQ9: Feedback input high disables contactor monitoring; low enables it.
// RQ10: Non-muting model: mode input high enables interlock; bridge disables.
// RQ11: Muting-capable models keep the restart interlock always active.
// RQ12: Pin 2 high, pin 7 low: bridge 4 mode 1, 8 mode 2, 3 mode 4.
// RQ13: Pin 2 low, pin 7 high: bridge 8 mode 3, 4 mode 5, 3 mode 6.
// RQ14: Muting timeout 10 min in modes 1, 3, 5, 6; 100 h in 2, 4.
// RQ15: Modes 3 and 4 sequence controlled; modes 1, 2, 5, 6 timing controlled.
// RQ16: Timing modes use two sensors on five-pin socket, four on eight-pin.
// RQ17: Interlock in every muting mode; contactor monitoring only 1, 2, 3, 5.
// RQ18: Timeout extension in 1, 5, 6; muting-enable 5; partial muting 6.
// RQ19: Second muting signal from local sensor or controller on main plug.
// RQ20: Unknown strap combination flags a configuration fault, outputs off.

package scm_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 200_000_000;
   localparam int unsigned DELAY_SHORT_MS  = 100;
   localparam int unsigned DELAY_LONG_MS   = 500;
   localparam longint unsigned DELAY_SHORT_CYC =
      longint'(CLK_HZ) / 1000 * DELAY_SHORT_MS;
   localparam longint unsigned DELAY_LONG_CYC  =
      longint'(CLK_HZ) / 1000 * DELAY_LONG_MS;
   localparam int unsigned TIMEOUT_SHORT_MIN = 10;
   localparam int unsigned TIMEOUT_LONG_H    = 100;
   localparam int unsigned DELAY_W           = 28;
   localparam int unsigned CODE_W            = 4;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic RST_DELAY_SEL   = 1'h0;
   localparam logic RST_INTERF_FLAG = 1'h0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      MODE_NONE = 3'h0,
      MODE_1    = 3'h1,
      MODE_2    = 3'h2,
      MODE_3    = 3'h3,
      MODE_4    = 3'h4,
      MODE_5    = 3'h5,
      MODE_6    = 3'h6,
      MODE_BAD  = 3'h7
   } scm_mode_e;

   typedef enum logic [1:0]
   {
      BR_NONE = 2'h0,
      BR_PIN4 = 2'h1,
      BR_PIN8 = 2'h2,
      BR_PIN3 = 2'h3
   } scm_bridge_e;

   // Strap levels as seen at the plug, 1 meaning +24 V.
   typedef struct packed
   {
      logic        muting_model;
      logic        eight_pin_socket;
      logic        pin2_high;
      logic        pin7_high;
      scm_bridge_e bridge;
      logic        feedback_high;
      logic        mode_input_high;
   } scm_straps_s;

   typedef struct packed
   {
      scm_mode_e mode;
      logic      restart_interlock;
      logic      contactor_feedback_monitor;
      logic      sequence_muting;
      logic      four_sensor;
      logic      timeout_long;
      logic      timeout_ext_allowed;
      logic      muting_enable;
      logic      partial_muting;
      logic      msig2_on_plug;
      logic      config_fault;
   } scm_cfg_s;

   typedef struct packed
   {
      logic restart_delay_select;
      logic interference_flag;
   } scm_param_s;

endpackage

/* File: rtl/scm_decode.sv */
// Purpose: Combinational decode of strap levels into a configuration.
// Assumes: Straps are stable while the loader captures them.
// Notes:   Pure logic; the caller registers the result once.

module scm_decode
(
   input  wire scm_pkg::scm_straps_s straps,
   output scm_pkg::scm_cfg_s         cfg
);

   always_comb
   begin
      cfg = '0;
      if (!straps.muting_model)
      begin
         cfg.mode                       = scm_pkg::MODE_NONE;
         cfg.restart_interlock          = straps.mode_input_high;   // RQ10
         cfg.contactor_feedback_monitor = !straps.feedback_high;    // RQ9
      end
      else
      begin
         if (straps.pin2_high && !straps.pin7_high)
         begin
            unique case (straps.bridge)                          // RQ12
               scm_pkg::BR_PIN4: cfg.mode = scm_pkg::MODE_1;
               scm_pkg::BR_PIN8: cfg.mode = scm_pkg::MODE_2;
               scm_pkg::BR_PIN3: cfg.mode = scm_pkg::MODE_4;
               scm_pkg::BR_NONE: cfg.mode = scm_pkg::MODE_BAD;
            endcase
         end
         else if (!straps.pin2_high && straps.pin7_high)
         begin
            unique case (straps.bridge)                          // RQ13
               scm_pkg::BR_PIN8: cfg.mode = scm_pkg::MODE_3;
               scm_pkg::BR_PIN4: cfg.mode = scm_pkg::MODE_5;
               scm_pkg::BR_PIN3: cfg.mode = scm_pkg::MODE_6;
               scm_pkg::BR_NONE: cfg.mode = scm_pkg::MODE_BAD;
            endcase
         end
         else
         begin
            cfg.mode = scm_pkg::MODE_BAD;
         end
         cfg.config_fault      = (cfg.mode == scm_pkg::MODE_BAD); // RQ20
         cfg.restart_interlock = 1'b1;                         // RQ11 RQ17
         cfg.contactor_feedback_monitor = !straps.feedback_high // RQ17
            && (cfg.mode inside {scm_pkg::MODE_1, scm_pkg::MODE_2,
                                 scm_pkg::MODE_3, scm_pkg::MODE_5});
         cfg.sequence_muting = (cfg.mode inside            // RQ15
            {scm_pkg::MODE_3, scm_pkg::MODE_4});
         cfg.four_sensor = straps.eight_pin_socket         // RQ16
            && !cfg.sequence_muting && !cfg.config_fault;
         cfg.timeout_long = (cfg.mode inside               // RQ14
            {scm_pkg::MODE_2, scm_pkg::MODE_4});
         cfg.timeout_ext_allowed = (cfg.mode inside        // RQ18
            {scm_pkg::MODE_1, scm_pkg::MODE_5, scm_pkg::MODE_6});
         cfg.muting_enable  = (cfg.mode == scm_pkg::MODE_5); // RQ18
         cfg.partial_muting = (cfg.mode == scm_pkg::MODE_6); // RQ18
         cfg.msig2_on_plug  = (cfg.mode inside             // RQ19
            {scm_pkg::MODE_2, scm_pkg::MODE_3, scm_pkg::MODE_4});
         if (cfg.config_fault)
         begin
            cfg.restart_interlock = 1'b1;
         end
      end
   end

endmodule

/* File: rtl/scm_delay.sv */
// Purpose: Restart delay timer started by a beam interruption end.
// Assumes: Start is a one-cycle pulse.
// Notes:   Done pulses once when the selected delay has elapsed.

module scm_delay
#(
   parameter longint unsigned SHORT_CYC = scm_pkg::DELAY_SHORT_CYC,
   parameter longint unsigned LONG_CYC  = scm_pkg::DELAY_LONG_CYC
)
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic start,
   input  wire logic long_sel,
   output logic      busy,
   output logic      done
);

   typedef struct packed
   {
      logic                            busy;
      logic                            done;
      logic [scm_pkg::DELAY_W-1:0]     cnt;
   } scm_dly_s;

   scm_dly_s s_q;
   scm_dly_s s_d;

   localparam logic [scm_pkg::DELAY_W-1:0] SHORT_LAST =
      scm_pkg::DELAY_W'(SHORT_CYC - 1);
   localparam logic [scm_pkg::DELAY_W-1:0] LONG_LAST =
      scm_pkg::DELAY_W'(LONG_CYC - 1);

   always_comb
   begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (start)
      begin
         s_d.busy = 1'b1;                                      // RQ1
         s_d.cnt  = long_sel ? LONG_LAST : SHORT_LAST;         // RQ1
      end
      else if (s_q.busy)
      begin
         if (s_q.cnt == '0)
         begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end
         else
         begin
            s_d.cnt = s_q.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign busy = s_q.busy;
   assign done = s_q.done;

endmodule

/* File: rtl/scm_top.sv */
// Purpose: Start-up strap loader, parameter port and safe-bus data bits.
// Assumes: The bus master writes parameters with a one-cycle strobe.
// Notes:   Configuration is frozen after the first clock edge past reset.

module scm_top
#(
   parameter longint unsigned SHORT_CYC = scm_pkg::DELAY_SHORT_CYC,
   parameter longint unsigned LONG_CYC  = scm_pkg::DELAY_LONG_CYC
)
(
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire scm_pkg::scm_straps_s        straps,
   input  wire logic                        param_wr,
   input  wire scm_pkg::scm_param_s         param_wdata,
   output scm_pkg::scm_param_s              param_rdata,
   input  wire logic                        indicator_out_bit,
   output logic                             muting_lamp,
   input  wire logic [scm_pkg::CODE_W-1:0]  code_word,
   output logic [scm_pkg::CODE_W-1:0]       safety_code_inputs,
   input  wire logic                        interference_event,
   input  wire logic                        beam_clear,
   output logic                             restart_delay_busy,
   output logic                             restart_delay_done,
   output scm_pkg::scm_cfg_s                cfg,
   output logic                             cfg_valid,
   output logic                             safety_switch_output_allow
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic                         loaded;
      scm_pkg::scm_cfg_s            cfg;
      scm_pkg::scm_param_s          par;
      logic                         lamp;
      logic [scm_pkg::CODE_W-1:0]   code;
      logic                         beam_clear_prev;
   } scm_top_s;

   scm_top_s          s_q;
   scm_top_s          s_d;
   scm_pkg::scm_cfg_s dec_cfg;
   logic              dly_start;

   scm_decode u_decode
   (
      .straps (straps),
      .cfg    (dec_cfg)
   );

   // Restart delay begins when the beam becomes clear again.
   assign dly_start = beam_clear && !s_q.beam_clear_prev;

   scm_delay
   #(
      .SHORT_CYC (SHORT_CYC),
      .LONG_CYC  (LONG_CYC)
   )
   u_delay
   (
      .clk      (clk),
      .rst      (rst),
      .start    (dly_start),
      .long_sel (s_q.par.restart_delay_select),
      .busy     (restart_delay_busy),
      .done     (restart_delay_done)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d                 = s_q;
      s_d.beam_clear_prev = beam_clear;
      // Capturing only once avoids a live strap edit changing safety modes.
      if (!s_q.loaded)
      begin
         s_d.loaded = 1'b1;                                    // RQ8
         s_d.cfg    = dec_cfg;                                 // RQ8
      end
      if (param_wr)
      begin
         s_d.par.restart_delay_select =
            param_wdata.restart_delay_select;                  // RQ1
         s_d.par.interference_flag = param_wdata.interference_flag; // RQ2
      end
      // Interference wins over a simultaneous master write of 1.
      if (interference_event)
      begin
         s_d.par.interference_flag = 1'b0;                     // RQ4
      end
      s_d.lamp = indicator_out_bit;                            // RQ6
      s_d.code = code_word;                                    // RQ7
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_q                          <= '0;
         s_q.par.restart_delay_select <= scm_pkg::RST_DELAY_SEL;
         s_q.par.interference_flag    <= scm_pkg::RST_INTERF_FLAG;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign param_rdata        = s_q.par;                        // RQ3
   assign muting_lamp        = s_q.lamp;                       // RQ6
   assign safety_code_inputs = s_q.code;                       // RQ7
   assign cfg                = s_q.cfg;
   assign cfg_valid          = s_q.loaded;
   // Parameter port bits take no part in this enable.
   assign safety_switch_output_allow =
      s_q.loaded && !s_q.cfg.config_fault;                     // RQ20 RQ5

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic loaded_prev;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         loaded_prev <= 1'b0;
      end
      else
      begin
         loaded_prev <= s_q.loaded;
      end
   end

   chk_cfg_frozen: assert property (@(posedge clk) disable iff (rst) // RQ8
      loaded_prev |-> $stable(cfg))
      else $error("Configuration changed after start-up.");

   chk_fault_off: assert property (@(posedge clk) disable iff (rst) // RQ20
      (cfg.config_fault || cfg.mode == scm_pkg::MODE_BAD)
      |-> (cfg.config_fault && !safety_switch_output_allow))
      else $error("Outputs allowed under configuration fault.");

   chk_interf_clear: assert property (@(posedge clk) disable iff (rst) // RQ4
      interference_event |=> !param_rdata.interference_flag)
      else $error("Interference did not clear the flag.");

   chk_interf_hold: assert property (@(posedge clk) disable iff (rst) // RQ3
      (param_rdata.interference_flag && !param_wr && !interference_event)
      |=> param_rdata.interference_flag)
      else $error("Interference flag dropped without cause.");

   chk_lamp_follow: assert property (@(posedge clk) disable iff (rst) // RQ6
      ##1 muting_lamp == $past(indicator_out_bit))
      else $error("Muting lamp does not follow output bit.");

   chk_code_follow: assert property (@(posedge clk) disable iff (rst) // RQ7
      ##1 safety_code_inputs == $past(code_word))
      else $error("Code word not passed on.");

   chk_interlock_mut: assert property (@(posedge clk) disable iff (rst) // RQ11
      (cfg_valid && cfg.mode != scm_pkg::MODE_NONE)
      |-> cfg.restart_interlock)
      else $error("Interlock off on a muting model.");

   chk_edm_modes: assert property (@(posedge clk) disable iff (rst) // RQ17
      (cfg.mode inside {scm_pkg::MODE_4, scm_pkg::MODE_6})
      |-> !cfg.contactor_feedback_monitor)
      else $error("Contactor monitoring in mode 4 or 6.");

   chk_timeout_long: assert property (@(posedge clk) disable iff (rst) // RQ14
      (cfg_valid && (cfg.mode inside {scm_pkg::MODE_2, scm_pkg::MODE_4}))
      |-> cfg.timeout_long)
      else $error("Long timeout missing in mode 2 or 4.");

   chk_delay_start: assert property (@(posedge clk) disable iff (rst) // RQ1
      dly_start |=> restart_delay_busy)
      else $error("Restart delay did not start.");

   chk_delay_pulse: assert property (@(posedge clk) disable iff (rst) // RQ1
      restart_delay_done |-> (!restart_delay_busy ##1 !restart_delay_done))
      else $error("Restart delay done is not a single pulse.");

   chk_seq_modes: assert property (@(posedge clk) disable iff (rst) // RQ15
      (cfg_valid && (cfg.mode inside {scm_pkg::MODE_3, scm_pkg::MODE_4}))
      |-> (cfg.sequence_muting && !cfg.four_sensor))
      else $error("Sequence muting not selected in mode 3 or 4.");

   chk_ext_modes: assert property (@(posedge clk) disable iff (rst) // RQ18
      (cfg_valid && !(cfg.mode inside {scm_pkg::MODE_1, scm_pkg::MODE_5,
                                       scm_pkg::MODE_6}))
      |-> !(cfg.timeout_ext_allowed || cfg.muting_enable
            || cfg.partial_muting))
      else $error("Extension or enable offered outside its modes.");

   cov_fault: cover property (@(posedge clk) disable iff (rst)
      cfg_valid && cfg.config_fault);
   cov_mode6: cover property (@(posedge clk) disable iff (rst)
      cfg_valid && cfg.mode == scm_pkg::MODE_6);
   cov_interf: cover property (@(posedge clk) disable iff (rst)
      param_rdata.interference_flag ##1 !param_rdata.interference_flag);
   cov_delay: cover property (@(posedge clk) disable iff (rst)
      restart_delay_done);
   cov_wr_clash: cover property (@(posedge clk) disable iff (rst)
      param_wr && interference_event);

endmodule

/* File: verif/scm_master_model.sv */
// Purpose: Model of the bus master and the plug strap wiring.
// Assumes: The bench calls the tasks from one process at a time.
// Notes:   Each write is a strobe of one cycle, launched at a rising edge.

module scm_master_model
(
   input  wire logic            clk,
   output scm_pkg::scm_straps_s straps,
   output logic                 param_wr,
   output scm_pkg::scm_param_s  param_wdata,
   output logic                 indicator_out_bit
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      straps = '0;
      param_wr = 1'h0;
      param_wdata = '0;
      indicator_out_bit = 1'h0;
   end

   // ----------------------------------------------------------------
   // Master actions
   // ----------------------------------------------------------------
   // Only this model drives the parameter port, and nothing safety
   // related is derived from it on the bench side.
   task automatic write_param(input logic sel, input logic flag);
      @(posedge clk);
      param_wr <= 1'h1;
      param_wdata <= '{restart_delay_select: sel,
                       interference_flag: flag};
      @(posedge clk);
      param_wr <= 1'h0;
      // Released data flips so a stale value cannot look like a write.
      param_wdata <= scm_pkg::scm_param_s'(~param_wdata);
   endtask

   task automatic set_lamp(input logic v);
      @(posedge clk);
      indicator_out_bit <= v;
   endtask

   // Straps model the plug wiring: pins 2 and 7, the bridge and the other strap levels.
   task automatic set_straps(input scm_pkg::scm_straps_s s);
      @(posedge clk);
      straps <= s;
   endtask
endmodule

/* File: verif/safety_curtain_mode_config_bench.sv */
// Purpose: Self-checking bench for the strap loader and parameter port.
// Assumes: Delay counts are shortened to keep the run brief.
// Notes:   Each strap set is applied before a reset, as at power-up.

module safety_curtain_mode_config_bench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam longint unsigned SHORT = 10;
   localparam longint unsigned LONG  = 50;

   logic                 clk;
   logic                 rst;
   scm_pkg::scm_straps_s straps;
   logic                 param_wr;
   scm_pkg::scm_param_s  param_wdata;
   scm_pkg::scm_param_s  param_rdata;
   logic                 indicator_out_bit;
   logic                 muting_lamp;
   logic [3:0]           code_word;
   logic [3:0]           safety_code_inputs;
   logic                 interference_event;
   logic                 beam_clear;
   logic                 busy;
   logic                 done;
   scm_pkg::scm_cfg_s    cfg;
   logic                 cfg_valid;
   logic                 allow;
   int                   mismatches;
   int                   n_tests;
   int                   cycles;

   scm_top #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) i_dut
   (
      .clk                        (clk),
      .rst                        (rst),
      .straps                     (straps),
      .param_wr                   (param_wr),
      .param_wdata                (param_wdata),
      .param_rdata                (param_rdata),
      .indicator_out_bit          (indicator_out_bit),
      .muting_lamp                (muting_lamp),
      .code_word                  (code_word),
      .safety_code_inputs         (safety_code_inputs),
      .interference_event         (interference_event),
      .beam_clear                 (beam_clear),
      .restart_delay_busy         (busy),
      .restart_delay_done         (done),
      .cfg                        (cfg),
      .cfg_valid                  (cfg_valid),
      .safety_switch_output_allow (allow)
   );

   scm_master_model i_master
   (
      .clk               (clk),
      .straps            (straps),
      .param_wr          (param_wr),
      .param_wdata       (param_wdata),
      .indicator_out_bit (indicator_out_bit)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic stop_test();
      if (mismatches == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string msg);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic apply_reset();
      @(posedge clk);
      rst <= 1'h1;
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      @(negedge clk);
   endtask

   function automatic scm_pkg::scm_cfg_s exp_cfg(
      input scm_pkg::scm_straps_s s);
      scm_pkg::scm_cfg_s c;
      logic [2:0]        m;
      c = '0;
      if (!s.muting_model)
      begin
         c.restart_interlock = s.mode_input_high;
         c.contactor_feedback_monitor = !s.feedback_high;
         return c;
      end
      case ({s.pin2_high, s.pin7_high, s.bridge})
         4'h9: m = 3'h1;
         4'hA: m = 3'h2;
         4'hB: m = 3'h4;
         4'h6: m = 3'h3;
         4'h5: m = 3'h5;
         4'h7: m = 3'h6;
         default: m = 3'h7;
      endcase
      c.mode = scm_pkg::scm_mode_e'(m);
      c.config_fault = (m == 3'h7);
      c.restart_interlock = 1'h1;
      if (c.config_fault)
         return c;
      c.contactor_feedback_monitor = !s.feedback_high &&
                                     (m inside {3'h1, 3'h2, 3'h3, 3'h5});
      c.sequence_muting = m inside {3'h3, 3'h4};
      c.four_sensor = !c.sequence_muting && s.eight_pin_socket;
      c.timeout_long = m inside {3'h2, 3'h4};
      c.timeout_ext_allowed = m inside {3'h1, 3'h5, 3'h6};
      c.muting_enable = (m == 3'h5);
      c.partial_muting = (m == 3'h6);
      c.msig2_on_plug = m inside {3'h2, 3'h3, 3'h4};
      return c;
   endfunction

   task automatic run_cfg(input scm_pkg::scm_straps_s s);
      scm_pkg::scm_cfg_s e;
      e = exp_cfg(s);
      i_master.set_straps(s);
      apply_reset();
      check(16'(cfg.mode), 16'(e.mode), "mode");
      check(16'(cfg.config_fault), 16'(e.config_fault), "fault");
      check(16'({cfg_valid, allow}), 16'({1'h1, !e.config_fault}),
            "allow");
      if (!s.muting_model)
      begin
         check(16'(cfg.restart_interlock), 16'(e.restart_interlock),
               "rs");
         check(16'(cfg.contactor_feedback_monitor),
               16'(e.contactor_feedback_monitor), "fb");
      end
      else if (!e.config_fault)
         check(16'(cfg), 16'(e),
               "cfg");
      i_master.set_straps(scm_pkg::scm_straps_s'(~s));
      repeat (3) @(posedge clk);
      @(negedge clk);
      check(16'(cfg), 16'(e), "strap change");
   endtask

   task automatic run_delay(input logic sel, input int n);
      int cnt;
      cnt = 0;
      i_master.write_param(sel, 1'h1);
      @(posedge clk);
      beam_clear <= 1'h1;
      for (int k = 0; k < 200 && done !== 1'h1; k++)
      begin
         @(negedge clk);
         if (busy === 1'h1)
            cnt++;
      end
      check(16'(done), 16'h0001, "no done");
      check(16'(cnt), 16'(n), "delay length");
      @(negedge clk);
      check(16'({busy, done}), 16'h0000, "done width");
      @(posedge clk);
      beam_clear <= 1'h0;
   endtask

   // ----------------------------------------------------------------
   // Clock, watchdog and test sequence
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         mismatches++;
         stop_test();
      end
   end

   initial
   begin
      scm_pkg::scm_straps_s s;
      rst = 1'h1;
      code_word = 4'h0;
      interference_event = 1'h0;
      beam_clear = 1'h0;
      mismatches = 0;
      n_tests = 0;
      cycles = 0;
      apply_reset();
      check(16'(param_rdata), 16'({scm_pkg::RST_DELAY_SEL,
                                  scm_pkg::RST_INTERF_FLAG}),
            "reset");
      for (int i = 0; i < 68; i++)
      begin
         s = '0;
         s.muting_model = (i < 64);
         s.eight_pin_socket = i[0];
         s.mode_input_high = i[0];
         s.feedback_high = i[1];
         s.bridge = scm_pkg::scm_bridge_e'(i[3:2]);
         s.pin2_high = i[4];
         s.pin7_high = i[5];
         run_cfg(s);
      end
      for (int v = 0; v < 16; v++)
      begin
         i_master.set_lamp(v[0]);
         code_word <= 4'(v);
         @(posedge clk);
         @(negedge clk);
         check(16'({muting_lamp, safety_code_inputs}), 16'(v + 16 * v[0]),
               "copy");
      end
      run_delay(1'h0, int'(SHORT));
      run_delay(1'h1, int'(LONG));
      repeat (10) @(posedge clk);
      @(negedge clk);
      check(16'(param_rdata), 16'h0003, "flag held");
      @(posedge clk);
      interference_event <= 1'h1;
      @(posedge clk);
      interference_event <= 1'h0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check(16'(param_rdata), 16'h0002, "flag cleared");
      i_master.write_param(1'h0, 1'h1);
      @(posedge clk);
      @(negedge clk);
      check(16'(param_rdata), 16'h0001, "flag set");
      fork
         i_master.write_param(1'h0, 1'h1);
         begin
            @(posedge clk);
            interference_event <= 1'h1;
            @(posedge clk);
            interference_event <= 1'h0;
         end
      join
      @(posedge clk);
      @(negedge clk);
      check(16'(param_rdata), 16'h0000, "event over write");
      stop_test();
   end
endmodule
